/* csm_defs.svh */
// constants for the clock stop monitor
`ifndef CSM_DEFS_SVH
`define CSM_DEFS_SVH
`define CSM_WATCH_MODE_RESET   8'h00
`define CSM_WATCH_ENABLE_BIT   0
`define CSM_CAUSE_FLAG_BIT     1
`define CSM_MAIN_STOP_BIT      7
`define CSM_CPU_CUT_BIT        7
`define CSM_INT_OSC_STOP_BIT   0
`define CSM_MAIN_STATUS_BIT    1
`define CSM_SETTLE_LOG2        16
`define CSM_STOP_THRESHOLD     4
`define CSM_SYS_CLK_MHZ        25
`endif

/* csm_pkg.sv */
// types for the clock stop monitor
package csm_pkg;
  typedef enum logic [1:0] {
    CSM_IDLE,
    CSM_SETTLE,
    CSM_WATCH
  } csm_state_e;
  typedef enum logic [1:0] {
    CSM_CPU_ON_MAIN,
    CSM_CPU_ON_INTERNAL,
    CSM_CPU_ON_SUB
  } csm_cpu_src_e;
endpackage

/* csm_edge_watch.sv */
// detector that counts sampling ticks without a main clock edge
`timescale 1ns/100ps
`include "csm_defs.svh"
module csm_edge_watch #(
  parameter int THRESHOLD = `CSM_STOP_THRESHOLD
) (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic run_i,
  input  wire logic sample_tick_i,
  input  wire logic main_clk_level_i,
  output logic      stopped_o
);
  logic       sync_a;
  logic       sync_b;
  logic       last_level;
  logic [7:0] miss_count;

  // ----------------------------------------------------------------
  // synchroniser, first stage read only by second
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= main_clk_level_i;
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------------------------------
  // miss counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      last_level <= 1'b0;
      miss_count <= 8'h00;
      stopped_o  <= 1'b0;
    end else begin
      last_level <= sync_b;
      stopped_o  <= 1'b0;
      if (!run_i || sync_b != last_level) begin
        miss_count <= 8'h00;
      end else if (sample_tick_i) begin
        if (miss_count >= 8'(THRESHOLD - 1)) begin
          stopped_o  <= 1'b1;
          miss_count <= 8'h00;
        end else begin
          miss_count <= miss_count + 8'h01;
        end
      end
    end
  end
endmodule

/* csm_clock_stop_monitor.sv */
// clock stop monitor: mode register, suspend logic and reset generation
`timescale 1ns/100ps
`include "csm_defs.svh"
module csm_clock_stop_monitor
  import csm_pkg::*;
#(
  parameter int SETTLE_LOG2 = `CSM_SETTLE_LOG2,
  parameter int THRESHOLD   = `CSM_STOP_THRESHOLD
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic        int_reset_i,
  input  wire logic        mode_wr_byte_i,
  input  wire logic        mode_wr_bit_i,
  input  wire logic [2:0]  mode_bit_sel_i,
  input  wire logic [7:0]  mode_wdata_i,
  output logic      [7:0]  clock_watch_mode_reg_o,
  input  wire logic        main_osc_stop_i,
  input  wire logic        cpu_main_clock_cut_i,
  input  wire csm_cpu_src_e cpu_src_i,
  input  wire logic        stop_mode_i,
  input  wire logic        int_osc_stop_wr_i,
  input  wire logic        int_osc_stop_val_i,
  input  wire logic        int_osc_unstoppable_i,
  output logic             internal_osc_stop_o,
  input  wire logic        main_clk_level_i,
  input  wire logic        sample_tick_i,
  input  wire logic        main_tick_i,
  output logic             monitoring_o,
  output logic             watch_reset_o,
  output logic             watch_reset_cause_flag_o
);
  logic [7:0]        clock_watch_mode_reg;
  logic [7:0]        next_mode;
  logic              watch_enable;
  logic              main_halted;
  logic              suspend_hold;
  logic [SETTLE_LOG2:0] settle_count;
  logic              stopped;
  logic              first_cycle;
  csm_state_e        state;

  assign watch_enable = clock_watch_mode_reg[`CSM_WATCH_ENABLE_BIT];

  // ----------------------------------------------------------------
  // mode register write path
  // ----------------------------------------------------------------
  always_comb begin
    next_mode = clock_watch_mode_reg;
    if (mode_wr_byte_i) begin
      next_mode = mode_wdata_i;
    end else if (mode_wr_bit_i) begin
      next_mode[mode_bit_sel_i] = mode_wdata_i[0];
    end
    // bit 0 is write-one only; clearing comes from reset alone
    next_mode[`CSM_WATCH_ENABLE_BIT] = watch_enable |
                                       next_mode[`CSM_WATCH_ENABLE_BIT];
    next_mode[7:1] = 7'h00;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      clock_watch_mode_reg <= `CSM_WATCH_MODE_RESET;
    end else if (int_reset_i || watch_reset_o) begin
      clock_watch_mode_reg <= `CSM_WATCH_MODE_RESET;
    end else begin
      clock_watch_mode_reg <= next_mode;
    end
  end

  assign clock_watch_mode_reg_o = clock_watch_mode_reg;

  // ----------------------------------------------------------------
  // internal oscillator stop control
  // ----------------------------------------------------------------
  // status check before stopping is left to software
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      internal_osc_stop_o <= 1'b0;
    end else if (int_osc_unstoppable_i) begin
      internal_osc_stop_o <= 1'b0;
    end else if (int_osc_stop_wr_i) begin
      internal_osc_stop_o <= int_osc_stop_val_i;
    end
  end

  // ----------------------------------------------------------------
  // suspend conditions
  // ----------------------------------------------------------------
  always_comb begin
    case (cpu_src_i)
      CSM_CPU_ON_INTERNAL: main_halted = main_osc_stop_i;
      CSM_CPU_ON_SUB:      main_halted = cpu_main_clock_cut_i;
      default:             main_halted = 1'b0;
    endcase
  end

  // main clock absent: after reset, in STOP, or stopped by software
  assign suspend_hold = first_cycle | stop_mode_i | main_halted;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // settle timer and monitor state
  // ----------------------------------------------------------------
  // the settle time is counted in main clock periods regardless of
  // oscillator type, so an RC oscillator still waits it out
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state        <= CSM_SETTLE;
      settle_count <= '0;
    end else begin
      case (state)
        CSM_IDLE: begin
          if (!suspend_hold) begin
            state <= CSM_WATCH;
          end
        end
        CSM_SETTLE: begin
          if (suspend_hold) begin
            settle_count <= '0;
          end else if (settle_count[SETTLE_LOG2]) begin
            state        <= CSM_WATCH;
            settle_count <= '0;
          end else if (main_tick_i) begin
            settle_count <= settle_count + 1'b1;
          end
        end
        CSM_WATCH: begin
          if (suspend_hold) begin
            state        <= CSM_SETTLE;
            settle_count <= '0;
          end
        end
        default: begin
          state <= CSM_SETTLE;
        end
      endcase
    end
  end

  // enable may arrive any time; it only takes effect in the watch state
  assign monitoring_o = (state == CSM_WATCH) & watch_enable & ~internal_osc_stop_o &
                        ~suspend_hold;

  csm_edge_watch #(
    .THRESHOLD(THRESHOLD)
  ) u_edge_watch (
    .sys_clk_i       (sys_clk_i),
    .reset_i         (reset_i),
    .run_i           (monitoring_o),
    .sample_tick_i   (sample_tick_i),
    .main_clk_level_i(main_clk_level_i),
    .stopped_o       (stopped)
  );

  // ----------------------------------------------------------------
  // reset request and cause flag
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      watch_reset_o <= 1'b0;
    end else begin
      watch_reset_o <= stopped & monitoring_o;
    end
  end

  // flag survives the internal reset it causes; only external reset clears it
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      watch_reset_cause_flag_o <= 1'b0;
    end else if (watch_reset_o) begin
      watch_reset_cause_flag_o <= 1'b1;
    end
  end
endmodule

/* csm_checker_sva.sv */
// port assertions for the clock stop monitor
`timescale 1ns/100ps
module csm_checker_sva (
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic       int_reset_i,
  input wire logic       mode_wr_byte_i,
  input wire logic [7:0] mode_wdata_i,
  input wire logic [7:0] clock_watch_mode_reg_o,
  input wire logic       stop_mode_i,
  input wire logic       int_osc_unstoppable_i,
  input wire logic       internal_osc_stop_o,
  input wire logic       monitoring_o,
  input wire logic       watch_reset_o,
  input wire logic       watch_reset_cause_flag_o
);
  // either reset source may legally clear the enable bit
  wire       quiet = !int_reset_i && !watch_reset_o;
  wire [7:0] mode  = clock_watch_mode_reg_o;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // ---------------
  // port properties
  // ---------------
  AST_BYTE_SET: assert property (mode_wr_byte_i && mode_wdata_i[0] && quiet |=> mode[0])
    else $error("byte write did not set enable");
  AST_STICKY: assert property (mode[0] && quiet |=> mode[0])
    else $error("enable bit dropped without reset");
  AST_INT_CLEAR: assert property (int_reset_i |=> mode == 8'h00)
    else $error("internal reset left mode register set");
  AST_CAUSE: assert property (watch_reset_o |=>
    !watch_reset_o && watch_reset_cause_flag_o && mode == 8'h00)
    else $error("monitor reset did not clear enable and set cause");
  AST_IDLE: assert property (!mode[0] |-> !monitoring_o)
    else $error("monitoring while disabled");
  AST_SUSPEND: assert property (stop_mode_i || internal_osc_stop_o |-> !monitoring_o)
    else $error("monitoring while suspended");
  AST_SOURCE: assert property (watch_reset_o |-> $past(mode[0]))
    else $error("monitor reset without enable");
  AST_LOCKED: assert property (int_osc_unstoppable_i && !internal_osc_stop_o |=> !internal_osc_stop_o)
    else $error("oscillator stopped against option");
endmodule

/* csm_main_osc.sv */
// behavioural main oscillator watched by the monitor
`timescale 1ns/100ps
module csm_main_osc (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic halt_i,
  output logic      level_o,
  output logic      tick_o
);
  logic [1:0] phase;
  // a halted oscillator freezes its level, as a dead crystal would
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase <= 2'h0;
    end else if (!halt_i) begin
      phase <= phase + 2'h1;
    end
  end
  assign level_o = phase[1];
  assign tick_o  = phase == 2'h3 && !halt_i;
endmodule

/* csm_clock_stop_monitor_test.sv */
// self-checking bench for the clock stop monitor
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: port value differs from model", $time); end end
module csm_clock_stop_monitor_test;
  import csm_pkg::*;
  logic         sys_clk_i, reset_i, int_reset_i, mode_wr_byte_i, mode_wr_bit_i, osc_halt;
  logic [2:0]   mode_bit_sel_i;
  logic [2:0]   tick_cnt = 3'h0;
  logic [7:0]   mode_wdata_i, clock_watch_mode_reg_o;
  logic         main_osc_stop_i, cpu_main_clock_cut_i, stop_mode_i, int_osc_stop_wr_i;
  logic         int_osc_stop_val_i, int_osc_unstoppable_i, internal_osc_stop_o;
  logic         main_clk_level_i, sample_tick_i, main_tick_i, monitoring_o;
  logic         watch_reset_o, watch_reset_cause_flag_o;
  logic [16:0]  rnd;
  csm_cpu_src_e cpu_src_i;
  int           err_count, tests_run, exp_mode, exp_flag, i;
  csm_clock_stop_monitor #(.SETTLE_LOG2(4)) csm_clock_stop_monitor_inst (.*);
  // software stops and stop mode halt the oscillator itself
  csm_main_osc csm_main_osc_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .halt_i(osc_halt | main_osc_stop_i | cpu_main_clock_cut_i | stop_mode_i),
    .level_o(main_clk_level_i), .tick_o(main_tick_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // no sample ticks while the internal oscillator is stopped
  always @(negedge sys_clk_i) begin
    tick_cnt <= tick_cnt + 3'h1;
    sample_tick_i <= tick_cnt == 3'h0 && !internal_osc_stop_o;
  end
  // -------------
  // bench helpers
  // -------------
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic wr(input logic bit_wr, input logic [2:0] sel, input logic [7:0] d);
    @(negedge sys_clk_i);
    mode_wr_byte_i = !bit_wr;
    mode_wr_bit_i = bit_wr;
    mode_bit_sel_i = sel;
    mode_wdata_i = d;
    if (!bit_wr || sel == 3'h0) exp_mode = exp_mode | d[0];
    @(negedge sys_clk_i);
    mode_wr_byte_i = 1'b0;
    mode_wr_bit_i = 1'b0;
    `CHK(clock_watch_mode_reg_o, 8'(exp_mode))
  endtask
  task automatic wait_mon(input logic v);
    for (i = 0; i < 400 && monitoring_o !== v; i++) @(negedge sys_clk_i);
    `CHK(monitoring_o, v)
  endtask
  task automatic final_report;
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    err_count++;
    final_report;
  end
  // -------------
  // main sequence
  // -------------
  initial begin
    reset_i = 1'b1;
    {int_reset_i, mode_wr_byte_i, mode_wr_bit_i, main_osc_stop_i, cpu_main_clock_cut_i} = '0;
    {stop_mode_i, int_osc_stop_wr_i, int_osc_stop_val_i, int_osc_unstoppable_i, osc_halt} = '0;
    {mode_bit_sel_i, mode_wdata_i} = '0;
    cpu_src_i = CSM_CPU_ON_MAIN;
    rnd = 17'h17B30;
    {exp_mode, exp_flag, err_count, tests_run} = '0;
    repeat (10) @(negedge sys_clk_i);
    reset_i = 1'b0;
    `CHK(clock_watch_mode_reg_o, 8'h00)
    rnd = lfsr(rnd);
    wr(1'b0, 3'h0, {rnd[7:1], 1'b1});
    `CHK(monitoring_o, 1'b0)
    wait_mon(1'b1);
    rnd = lfsr(rnd);
    wr(1'b0, 3'h0, {rnd[7:1], 1'b0});
    wr(1'b1, 3'h0, 8'h00);
    stop_mode_i = 1'b1;
    wait_mon(1'b0);
    repeat (20) @(negedge sys_clk_i);
    stop_mode_i = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    `CHK(monitoring_o, 1'b0)
    wait_mon(1'b1);
    for (int k = 0; k < 2; k++) begin
      cpu_src_i = k == 0 ? CSM_CPU_ON_INTERNAL : CSM_CPU_ON_SUB;
      main_osc_stop_i = k == 0;
      cpu_main_clock_cut_i = k == 1;
      wait_mon(1'b0);
      repeat (40) @(negedge sys_clk_i);
      {main_osc_stop_i, cpu_main_clock_cut_i} = 2'h0;
      repeat (8) @(negedge sys_clk_i);
      `CHK(monitoring_o, 1'b0)
      wait_mon(1'b1);
    end
    for (int k = 0; k < 3; k++) begin
      int_osc_unstoppable_i = k == 0;
      int_osc_stop_wr_i = 1'b1;
      int_osc_stop_val_i = k != 2;
      @(negedge sys_clk_i);
      int_osc_stop_wr_i = 1'b0;
      @(negedge sys_clk_i);
      `CHK(internal_osc_stop_o, (k == 1))
      wait_mon(k != 1);
    end
    osc_halt = 1'b1;
    repeat (16) @(negedge sys_clk_i);
    `CHK(watch_reset_cause_flag_o, 1'b0)
    for (i = 0; i < 100 && watch_reset_o !== 1'b1; i++) @(negedge sys_clk_i);
    `CHK(watch_reset_o, 1'b1)
    exp_mode = 0;
    exp_flag = 1;
    @(negedge sys_clk_i);
    `CHK(clock_watch_mode_reg_o, 8'(exp_mode))
    `CHK(watch_reset_cause_flag_o, 1'(exp_flag))
    osc_halt = 1'b0;
    wr(1'b1, {1'b1, rnd[1:0]}, 8'h01);
    wr(1'b1, 3'h0, 8'h01);
    int_reset_i = 1'b1;
    @(negedge sys_clk_i);
    int_reset_i = 1'b0;
    exp_mode = 0;
    `CHK(clock_watch_mode_reg_o, 8'h00)
    wr(1'b0, 3'h0, 8'h01);
    reset_i = 1'b1;
    @(negedge sys_clk_i);
    reset_i = 1'b0;
    `CHK(clock_watch_mode_reg_o, 8'h00)
    `CHK(watch_reset_cause_flag_o, 1'b0)
    final_report;
  end
endmodule
bind csm_clock_stop_monitor csm_checker_sva csm_checker_sva_inst (.*);
